// file: inc/vci_defs.svh
// constants of the vector command interpreter: codes, limits, reset values
`ifndef VCI_DEFS_SVH
`define VCI_DEFS_SVH
// special characters
`define VCI_CR 8'h0d
`define VCI_LF 8'h0a
`define VCI_DIGIT0 8'h30
`define VCI_DIGIT9 8'h39
// two-letter command codes, first letter in the upper byte
`define VCI_CODE_JX 16'h4a58
`define VCI_CODE_JY 16'h4a59
`define VCI_CODE_NX 16'h4e58
`define VCI_CODE_NY 16'h4e59
`define VCI_CODE_AB 16'h4142
`define VCI_CODE_DL 16'h444c
`define VCI_CODE_SP 16'h5350
`define VCI_CODE_SS 16'h5353
`define VCI_CODE_JS 16'h4a53
// reply message letters, sent before the terminator
`define VCI_MSG_INV 16'h4941
`define VCI_MSG_OVF 16'h5446
// limits
`define VCI_COORD_MAX 17'h0ffff
`define VCI_TBL_PAIRS 15'h7d00
`define VCI_FIFO_DEPTH 8
// reset values of the settings
`define VCI_SP_RST 16'h0001
`define VCI_SS_RST 16'h0001
`define VCI_JS_RST 16'h0001
`endif

// file: inc/vci_pkg.sv
// types of the vector command interpreter
package vci_pkg;
	// decoded command
	typedef enum logic [3:0] {
		C_NONE = 4'h0, C_JX = 4'h1, C_JY = 4'h2, C_NX = 4'h3, C_NY = 4'h4,
		C_AB = 4'h5, C_DL = 4'h6, C_SP = 4'h7, C_SS = 4'h8, C_JS = 4'h9
	} vci_cmd_type;
	// parser position inside a line
	typedef enum logic [1:0] {P_C1 = 2'b00, P_C2 = 2'b01, P_ARG = 2'b10} vci_parse_type;
	// reply message in flight
	typedef enum logic [1:0] {M_NONE = 2'b00, M_INV = 2'b01, M_OVF = 2'b10} vci_msg_type;
	// one stored vector pair with the table settings in force
	typedef struct packed {
		logic draw;
		logic [15:0] x;
		logic [15:0] y;
		logic [15:0] drawStep;
		logic [15:0] jumpStep;
	} vci_entry_type;
endpackage

// file: inc/vci_byte_if.sv
// byte stream with valid and ready
`timescale 1ns/1ps
`default_nettype none
interface vci_byte_if #(parameter int W = 8);
	logic valid; // byte offered
	logic ready; // byte taken
	logic [W-1:0] data; // byte value
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

// file: design/vci_fifo.sv
// byte fifo between the input ports and the parser
`timescale 1ns/1ps
`default_nettype none
module vci_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic core_clk, // system clock
	input wire logic rstn, // async reset, low
	vci_byte_if.snk inp, // filling side
	vci_byte_if.src outp // draining side
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH]; // storage
	logic [AW-1:0] wrPtr_r, wrPtr_nxt; // write pointer
	logic [AW-1:0] rdPtr_r, rdPtr_nxt; // read pointer
	logic [AW:0] cnt_r, cnt_nxt; // fill level
	logic notFull_r, notFull_nxt; // registered ready
	logic push, pop;
	assign push = inp.valid && notFull_r;
	assign pop = outp.ready && (cnt_r != '0);
	assign inp.ready = notFull_r;
	assign outp.valid = (cnt_r != '0);
	assign outp.data = mem_r[rdPtr_r];
	// pointer and level update
	always_comb begin
		wrPtr_nxt = push ? wrPtr_r + 1'b1 : wrPtr_r;
		rdPtr_nxt = pop ? rdPtr_r + 1'b1 : rdPtr_r;
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		notFull_nxt = (cnt_nxt != (AW+1)'(DEPTH));
	end
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			cnt_r <= '0;
			notFull_r <= 1'b1;
		end else begin
			wrPtr_r <= wrPtr_nxt;
			rdPtr_r <= rdPtr_nxt;
			cnt_r <= cnt_nxt;
			notFull_r <= notFull_nxt;
		end
	end
	// storage write, no reset needed
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_r[wrPtr_r] <= inp.data;
		end
	end
endmodule // vci_fifo
`default_nettype wire

// file: design/vci_table_mem.sv
// vector table storage, one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none
module vci_table_mem #(
	parameter int WIDTH = 65,
	parameter int DEPTH = 32000
) (
	input wire logic core_clk, // system clock
	input wire logic wrEn, // write strobe
	input wire logic [$clog2(DEPTH)-1:0] wrAddr, // write index
	input wire logic [WIDTH-1:0] wrData, // entry written
	input wire logic [$clog2(DEPTH)-1:0] rdAddr, // read index
	output logic [WIDTH-1:0] rdData // entry read, one cycle later
);
	logic [WIDTH-1:0] mem_r [DEPTH]; // storage
	// write and registered read
	always_ff @(posedge core_clk) begin
		if (wrEn) begin
			mem_r[wrAddr] <= wrData;
		end
		rdData <= mem_r[rdAddr];
	end
endmodule // vci_table_mem
`default_nettype wire

// file: design/vci_cmd_interp.sv
// vector command interpreter: byte intake, parser, coordinate table, replies
// Behaviour
// RULE_01: carriage return ends every command and reply
// RULE_02: arguments arrive as ASCII decimal digits
// RULE_03: line feeds from either port dropped
// RULE_04: host sends two letters, argument, terminator
// RULE_05: serial both ways, parallel input only
// RULE_06: host never uses both ports together
// RULE_07: immediate settings act globally at once
// RULE_08: table settings stored with following vectors
// RULE_09: input state left while table executes
// RULE_10: coordinates are 16-bit unsigned
// RULE_11: host sends X then Y per vector
// RULE_12: table holds 32000 pairs, draw and jump
// RULE_13: host keeps downloads within table capacity
// RULE_14: host never mixes draw and jump halves
// RULE_15: jump pairs laser off, draw pairs on
// RULE_16: absolute mode stores argument as endpoint
// RULE_17: delta mode adds two's complement offset
// RULE_18: mode change applies to following coordinates
// RULE_19: mode commands take no argument, absolute default
// RULE_20: out-of-field delta rejected with serial message
// RULE_21: full table refuses pairs and reports overflow
// RULE_22: unknown or malformed lines are ignored
`include "vci_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module vci_cmd_interp
	import vci_pkg::*;
(
	input wire logic core_clk, // 200 MHz system clock
	input wire logic rstn, // async reset, active low
	input wire logic serRxValid, // serial receive byte offered
	input wire logic [7:0] serRxData, // serial receive byte
	output logic serRxReady, // serial receive byte taken
	output logic serTxValid, // serial reply byte offered
	output logic [7:0] serTxData, // serial reply byte
	input wire logic serTxReady, // serial reply byte taken
	input wire logic parStrobe, // parallel byte strobe pin, high
	input wire logic [7:0] parData, // parallel data pins
	output logic parBusy, // parallel port busy
	input wire logic execActive, // table executing
	input wire logic tableClear, // empty the table, one pulse
	output logic inputState, // accepting commands
	output logic [15:0] stepPeriod, // global step period
	output logic [14:0] tblCount, // pairs stored
	input wire logic [14:0] tblRdAddr, // executor read index
	output logic [64:0] tblRdData // executor read entry
);
	// first letters to command
	function automatic vci_cmd_type decodeCmd(input logic [7:0] a, input logic [7:0] b);
		case ({a, b})
			`VCI_CODE_JX: decodeCmd = C_JX;
			`VCI_CODE_JY: decodeCmd = C_JY;
			`VCI_CODE_NX: decodeCmd = C_NX;
			`VCI_CODE_NY: decodeCmd = C_NY;
			`VCI_CODE_AB: decodeCmd = C_AB;
			`VCI_CODE_DL: decodeCmd = C_DL;
			`VCI_CODE_SP: decodeCmd = C_SP;
			`VCI_CODE_SS: decodeCmd = C_SS;
			`VCI_CODE_JS: decodeCmd = C_JS;
			default: decodeCmd = C_NONE;
		endcase
	endfunction

	// new coordinate from base and argument; top bit flags out of field
	function automatic logic [16:0] resolveCoord(input logic [15:0] base,
			input logic [15:0] arg, input logic absMode);
		logic signed [17:0] sum;
		sum = $signed({2'b00, base}) + $signed({{2{arg[15]}}, arg});
		if (absMode) begin
			resolveCoord = {1'b0, arg}; // [RULE_16]
		end else begin
			resolveCoord = {(sum < 0) || (sum > $signed({1'b0, `VCI_COORD_MAX})),
				sum[15:0]}; // [RULE_17] [RULE_20]
		end
	endfunction

	// reply byte by message and position
	function automatic logic [7:0] msgByte(input vci_msg_type m, input logic [1:0] i);
		logic [15:0] txt;
		txt = (m == M_OVF) ? `VCI_MSG_OVF : `VCI_MSG_INV;
		case (i)
			2'd0: msgByte = txt[15:8];
			2'd1: msgByte = txt[7:0];
			default: msgByte = `VCI_CR; // [RULE_01]
		endcase
	endfunction

	// ---- intake: parallel pin synchronisers and fifo ----
	logic [2:0] strSync_r, strSync_nxt; // strobe sync chain
	logic [7:0] datS1_r, datS2_r, datS3_r; // data sync chain
	logic parLvl_r, parLvl_nxt; // agreed strobe level
	logic parBusy_r, parBusy_nxt; // busy to host
	logic parEvt; // new parallel byte
	logic rxPush; // byte to fifo
	vci_byte_if #(.W(8)) rxIf(); // ports to fifo
	vci_byte_if #(.W(8)) psIf(); // fifo to parser

	// strobe counts once second and third stages agree
	always_comb begin
		strSync_nxt = {strSync_r[1:0], parStrobe};
		parLvl_nxt = (strSync_r[1] == strSync_r[2]) ? strSync_r[2] : parLvl_r;
		parEvt = parLvl_nxt && !parLvl_r;
		parBusy_nxt = !rxIf.ready;
	end
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			strSync_r <= '0;
			datS1_r <= '0;
			datS2_r <= '0;
			datS3_r <= '0;
			parLvl_r <= 1'b0;
			parBusy_r <= 1'b0;
		end else begin
			strSync_r <= strSync_nxt;
			datS1_r <= parData;
			datS2_r <= datS1_r;
			datS3_r <= datS2_r;
			parLvl_r <= parLvl_nxt;
			parBusy_r <= parBusy_nxt;
		end
	end

	// serial has priority; the host never drives both at once
	always_comb begin
		if (serRxValid) begin // [RULE_06]
			rxPush = (serRxData != `VCI_LF); // [RULE_03]
			rxIf.data = serRxData;
		end else begin
			rxPush = parEvt && (datS3_r != `VCI_LF); // [RULE_03]
			rxIf.data = datS3_r;
		end
		rxIf.valid = rxPush;
	end
	assign serRxReady = rxIf.ready;
	assign parBusy = parBusy_r;

	vci_fifo #(.WIDTH(8), .DEPTH(`VCI_FIFO_DEPTH)) uFifo (
		.core_clk(core_clk),
		.rstn(rstn),
		.inp(rxIf),
		.outp(psIf)
	);

	// ---- parser and table state ----
	vci_parse_type ps_r, ps_nxt; // line position
	logic [7:0] c1_r, c1_nxt; // first letter
	logic [7:0] c2_r, c2_nxt; // second letter
	logic [16:0] arg_r, arg_nxt; // argument value
	logic hasArg_r, hasArg_nxt; // any digit seen
	logic bad_r, bad_nxt; // malformed argument
	logic absMode_r, absMode_nxt; // coordinate mode
	logic [15:0] curX_r, curX_nxt; // current x position
	logic [15:0] curY_r, curY_nxt; // current y position
	logic [15:0] pendX_r, pendX_nxt; // x awaiting its y
	logic pendVal_r, pendVal_nxt; // x held
	logic pendDraw_r, pendDraw_nxt; // held x is a draw
	logic [15:0] stepPer_r, stepPer_nxt; // immediate setting
	logic [15:0] drawStep_r, drawStep_nxt; // table setting, draws
	logic [15:0] jumpStep_r, jumpStep_nxt; // table setting, jumps
	logic [14:0] count_r, count_nxt; // pairs stored
	logic inState_r; // input state
	logic wrEn; // table write
	vci_entry_type wrEntry; // entry written
	vci_msg_type raise; // reply to start
	vci_msg_type msg_r, msg_nxt; // reply in flight
	logic popEn; // parser takes bytes
	logic [7:0] b; // byte from fifo
	logic [20:0] acc; // argument times ten plus digit
	logic [16:0] rx, ry; // resolved coordinates
	vci_cmd_type cmd; // decoded line
	logic okArg, noArg; // argument shape

	// bytes are taken only in input state with no reply pending
	assign popEn = inState_r && (msg_r == M_NONE) && !tableClear; // [RULE_09]
	assign psIf.ready = popEn;
	assign b = psIf.data;

	// line parse and command effect
	always_comb begin
		ps_nxt = ps_r;
		c1_nxt = c1_r;
		c2_nxt = c2_r;
		arg_nxt = arg_r;
		hasArg_nxt = hasArg_r;
		bad_nxt = bad_r;
		absMode_nxt = absMode_r;
		curX_nxt = curX_r;
		curY_nxt = curY_r;
		pendX_nxt = pendX_r;
		pendVal_nxt = pendVal_r;
		pendDraw_nxt = pendDraw_r;
		stepPer_nxt = stepPer_r;
		drawStep_nxt = drawStep_r;
		jumpStep_nxt = jumpStep_r;
		count_nxt = count_r;
		wrEn = 1'b0;
		raise = M_NONE;
		cmd = decodeCmd(c1_r, c2_r);
		okArg = hasArg_r && !bad_r;
		noArg = !hasArg_r && !bad_r;
		rx = resolveCoord(curX_r, arg_r[15:0], absMode_r);
		ry = resolveCoord(curY_r, arg_r[15:0], absMode_r);
		acc = {1'b0, arg_r, 3'b000} + {3'b000, arg_r, 1'b0} + {17'h00000, b[3:0]};
		wrEntry.draw = pendDraw_r; // [RULE_15]
		wrEntry.x = pendX_r;
		wrEntry.y = ry[15:0];
		wrEntry.drawStep = drawStep_r; // [RULE_08]
		wrEntry.jumpStep = jumpStep_r; // [RULE_08]
		if (tableClear) begin
			// empty table, drop a half pair
			count_nxt = '0;
			pendVal_nxt = 1'b0;
		end else if (popEn && psIf.valid) begin
			case (ps_r)
				P_C1: begin
					// empty lines are skipped
					if (b != `VCI_CR) begin
						c1_nxt = b;
						ps_nxt = P_C2;
					end
				end
				P_C2: begin
					// one-letter line is dropped
					if (b == `VCI_CR) begin // [RULE_22]
						ps_nxt = P_C1;
					end else begin
						c2_nxt = b;
						arg_nxt = '0;
						hasArg_nxt = 1'b0;
						bad_nxt = 1'b0;
						ps_nxt = P_ARG;
					end
				end
				P_ARG: begin
					if (b != `VCI_CR) begin
						// decimal accumulate, anything else spoils the line
						if (b >= `VCI_DIGIT0 && b <= `VCI_DIGIT9) begin // [RULE_02]
							arg_nxt = acc[16:0];
							hasArg_nxt = 1'b1;
							if (acc > {4'h0, `VCI_COORD_MAX}) begin // [RULE_10]
								bad_nxt = 1'b1;
							end
						end else begin
							bad_nxt = 1'b1; // [RULE_22]
						end
					end else begin
						// terminator: carry out the line
						ps_nxt = P_C1; // [RULE_01]
						case (cmd)
							C_JX, C_NX: begin
								if (okArg) begin
									if (rx[16]) begin
										raise = M_INV; // [RULE_20]
									end else begin
										curX_nxt = rx[15:0];
										pendX_nxt = rx[15:0];
										pendVal_nxt = 1'b1;
										pendDraw_nxt = (cmd == C_NX);
									end
								end
							end
							C_JY, C_NY: begin
								// y only pairs with a held x of its kind
								if (okArg && pendVal_r && (pendDraw_r == (cmd == C_NY))) begin
									pendVal_nxt = 1'b0;
									if (count_r == `VCI_TBL_PAIRS) begin
										raise = M_OVF; // [RULE_21]
									end else if (ry[16]) begin
										raise = M_INV; // [RULE_20]
									end else begin
										curY_nxt = ry[15:0];
										wrEn = 1'b1; // [RULE_12]
										count_nxt = count_r + 15'h0001;
									end
								end
							end
							C_AB: if (noArg) absMode_nxt = 1'b1; // [RULE_19] [RULE_18]
							C_DL: if (noArg) absMode_nxt = 1'b0; // [RULE_19] [RULE_18]
							C_SP: if (okArg) stepPer_nxt = arg_r[15:0]; // [RULE_07]
							C_SS: if (okArg) drawStep_nxt = arg_r[15:0]; // [RULE_08]
							C_JS: if (okArg) jumpStep_nxt = arg_r[15:0]; // [RULE_08]
							default: ; // unknown code ignored [RULE_22]
						endcase
					end
				end
				default: ps_nxt = P_C1;
			endcase
		end
	end
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ps_r <= P_C1;
			c1_r <= '0;
			c2_r <= '0;
			arg_r <= '0;
			hasArg_r <= 1'b0;
			bad_r <= 1'b0;
			absMode_r <= 1'b1; // [RULE_19]
			curX_r <= '0;
			curY_r <= '0;
			pendX_r <= '0;
			pendVal_r <= 1'b0;
			pendDraw_r <= 1'b0;
			stepPer_r <= `VCI_SP_RST;
			drawStep_r <= `VCI_SS_RST;
			jumpStep_r <= `VCI_JS_RST;
			count_r <= '0;
			inState_r <= 1'b0;
		end else begin
			ps_r <= ps_nxt;
			c1_r <= c1_nxt;
			c2_r <= c2_nxt;
			arg_r <= arg_nxt;
			hasArg_r <= hasArg_nxt;
			bad_r <= bad_nxt;
			absMode_r <= absMode_nxt;
			curX_r <= curX_nxt;
			curY_r <= curY_nxt;
			pendX_r <= pendX_nxt;
			pendVal_r <= pendVal_nxt;
			pendDraw_r <= pendDraw_nxt;
			stepPer_r <= stepPer_nxt;
			drawStep_r <= drawStep_nxt;
			jumpStep_r <= jumpStep_nxt;
			count_r <= count_nxt;
			inState_r <= !execActive; // [RULE_09]
		end
	end
	assign inputState = inState_r;
	assign stepPeriod = stepPer_r;
	assign tblCount = count_r;

	vci_table_mem #(.WIDTH($bits(vci_entry_type)), .DEPTH(32000)) uTable (
		.core_clk(core_clk),
		.wrEn(wrEn),
		.wrAddr(count_r),
		.wrData(wrEntry),
		.rdAddr(tblRdAddr),
		.rdData(tblRdData)
	);

	// ---- serial replies, only this port answers ----
	logic [1:0] idx_r, idx_nxt; // byte of message
	logic txValid_r, txValid_nxt; // reply byte offered
	logic [7:0] txData_r, txData_nxt; // reply byte

	// two letters then terminator
	always_comb begin
		msg_nxt = msg_r;
		idx_nxt = idx_r;
		txValid_nxt = txValid_r;
		txData_nxt = txData_r;
		if (msg_r == M_NONE) begin
			if (raise != M_NONE) begin
				msg_nxt = raise; // [RULE_05]
				idx_nxt = 2'd0;
				txValid_nxt = 1'b1;
				txData_nxt = msgByte(raise, 2'd0);
			end
		end else if (txValid_r && serTxReady) begin
			if (idx_r == 2'd2) begin
				msg_nxt = M_NONE;
				txValid_nxt = 1'b0;
			end else begin
				idx_nxt = idx_r + 2'd1;
				txData_nxt = msgByte(msg_r, idx_r + 2'd1); // [RULE_01]
			end
		end
	end
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			msg_r <= M_NONE;
			idx_r <= 2'd0;
			txValid_r <= 1'b0;
			txData_r <= '0;
		end else begin
			msg_r <= msg_nxt;
			idx_r <= idx_nxt;
			txValid_r <= txValid_nxt;
			txData_r <= txData_nxt;
		end
	end
	assign serTxValid = txValid_r;
	assign serTxData = txData_r;
endmodule // vci_cmd_interp
`default_nettype wire

// file: test/vci_cmd_interp_props.sv
// port assertions of the vector command interpreter
`timescale 1ns/1ps
`default_nettype none
module vci_cmd_interp_props (
	input wire logic core_clk, // system clock
	input wire logic rstn, // async reset, low
	input wire logic serTxValid, // reply byte offered
	input wire logic [7:0] serTxData, // reply byte
	input wire logic serTxReady, // reply byte taken
	input wire logic execActive, // table executing
	input wire logic tableClear, // empty table pulse
	input wire logic inputState, // accepting commands
	input wire logic [15:0] stepPeriod, // global step period
	input wire logic [14:0] tblCount // pairs stored
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	logic txTake; // reply byte handed over this edge
	assign txTake = serTxValid && serTxReady;
	// a reply byte waits for the host
	AST_TX_HOLD: assert property (serTxValid && !serTxReady |=> serTxValid && $stable(serTxData))
		else $error("reply byte changed before taken");
	AST_TX_INV: assert property (txTake && serTxData == 8'h49 |=> serTxValid && serTxData == 8'h41)
		else $error("invalid reply second letter wrong");
	AST_TX_OVF: assert property (txTake && serTxData == 8'h54 |=> serTxValid && serTxData == 8'h46)
		else $error("overflow reply second letter wrong");
	// every reply closes with a carriage return, then goes quiet
	AST_TX_TERM: assert property (txTake && (serTxData == 8'h41 || serTxData == 8'h46) |=> serTxValid && serTxData == 8'h0d)
		else $error("reply not terminated");
	AST_TX_END: assert property (txTake && serTxData == 8'h0d |=> !serTxValid)
		else $error("reply continues after terminator");
	// input state is the inverse of execution, one cycle late
	AST_INPUT_STATE: assert property (rstn |=> inputState != $past(execActive))
		else $error("input state not inverse of execution");
	AST_SP_INPUT: assert property (!$stable(stepPeriod) |-> $past(inputState))
		else $error("step period changed outside input state");
	// count moves by single pairs or back to zero, never past capacity
	AST_CNT_STEP: assert property (!$stable(tblCount) |-> tblCount == 15'h0 || tblCount == $past(tblCount) + 15'h1)
		else $error("pair count jumped");
	AST_CNT_CAP: assert property (tblCount <= 15'h7d00)
		else $error("pair count above capacity");
	AST_CLEAR: assert property (tableClear |=> tblCount == 15'h0)
		else $error("clear left pairs");
	// main scenarios reached
	cover property (txTake && serTxData == 8'h0d);
	cover property (!$stable(stepPeriod));
	cover property (tblCount == $past(tblCount) + 15'h1);
endmodule // vci_cmd_interp_props
bind vci_cmd_interp vci_cmd_interp_props chk (.core_clk(core_clk), .rstn(rstn),
	.serTxValid(serTxValid), .serTxData(serTxData), .serTxReady(serTxReady),
	.execActive(execActive), .tableClear(tableClear), .inputState(inputState),
	.stepPeriod(stepPeriod), .tblCount(tblCount));
`default_nettype wire

// file: test/vci_host_model.sv
// host model: serial sender and reply taker, parallel sender
`timescale 1ns/1ps
`default_nettype none
module vci_host_model (
	input wire logic core_clk, // system clock
	output logic serRxValid, // byte offered
	output logic [7:0] serRxData, // byte value
	input wire logic serRxReady, // byte taken
	input wire logic serTxValid, // reply offered
	input wire logic [7:0] serTxData, // reply byte
	output logic serTxReady, // reply taken
	output logic parStrobe, // parallel strobe
	output logic [7:0] parData // parallel data
);
	logic slowTx = 1'b0; // stall replies when set
	logic [1:0] stallCnt = 2'h0; // stall phase
	logic [7:0] replyQ[$]; // reply bytes taken
	initial begin
		serRxValid = 1'b0;
		serRxData = 8'h0;
		serTxReady = 1'b1;
		parStrobe = 1'b0;
		parData = 8'h0;
	end
	// take replies, one in four cycles when slow
	always @(posedge core_clk) begin
		if (serTxValid === 1'b1 && serTxReady === 1'b1) begin
			replyQ.push_back(serTxData);
		end
		stallCnt <= stallCnt + 2'h1;
		serTxReady <= !slowTx || stallCnt == 2'h3;
	end
	// ports used one after the other, never together
	// bytes go out in string order, each held until taken; a line can span calls
	task automatic sendSer(input string s);
		for (int i = 0; i < s.len(); i++) begin
			serRxValid <= 1'b1;
			serRxData <= s[i];
			@(posedge core_clk);
			while (serRxReady !== 1'b1) @(posedge core_clk);
		end
		serRxValid <= 1'b0;
		serRxData <= ~serRxData;
		@(posedge core_clk);
	endtask
	// data settles before the strobe and is held past its sampling
	task automatic sendPar(input string s);
		for (int i = 0; i < s.len(); i++) begin
			parData <= s[i];
			repeat (4) @(posedge core_clk);
			parStrobe <= 1'b1;
			repeat (4) @(posedge core_clk);
			parStrobe <= 1'b0;
			repeat (4) @(posedge core_clk);
		end
		// spoil the lines once the last byte is seen, one write per step
		parData <= ~parData;
		@(posedge core_clk);
	endtask
endmodule // vci_host_model
`default_nettype wire

// file: test/vci_cmd_interp_test.sv
// self-checking testbench of the vector command interpreter
`timescale 1ns/1ps
`default_nettype none
module vci_cmd_interp_test
	import vci_pkg::*;
;
	logic core_clk = 1'b0; // 200 MHz clock
	logic rstn; // reset, low
	logic serRxValid, serRxReady, serTxValid, serTxReady, parStrobe, parBusy; // handshakes
	logic [7:0] serRxData, serTxData, parData; // byte lanes
	logic execActive, tableClear, inputState; // execution control
	logic [15:0] stepPeriod; // global step period
	logic [14:0] tblCount, tblRdAddr; // count and read index
	logic [64:0] tblRdData; // entry read
	int n_fail = 0; // mismatches
	int samples_checked = 0; // comparisons
	vci_cmd_interp DUT (.core_clk(core_clk), .rstn(rstn), .serRxValid(serRxValid),
		.serRxData(serRxData), .serRxReady(serRxReady), .serTxValid(serTxValid),
		.serTxData(serTxData), .serTxReady(serTxReady), .parStrobe(parStrobe),
		.parData(parData), .parBusy(parBusy), .execActive(execActive),
		.tableClear(tableClear), .inputState(inputState), .stepPeriod(stepPeriod),
		.tblCount(tblCount), .tblRdAddr(tblRdAddr), .tblRdData(tblRdData));
	vci_host_model host (.core_clk(core_clk), .serRxValid(serRxValid),
		.serRxData(serRxData), .serRxReady(serRxReady), .serTxValid(serTxValid),
		.serTxData(serTxData), .serTxReady(serTxReady), .parStrobe(parStrobe),
		.parData(parData));
	// clock
	initial begin
		forever #2.5 core_clk = ~core_clk;
	end
	// compare and count
	task automatic chk(input string what, input logic [71:0] exp, input logic [71:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// parser pops a byte a cycle, so a full fifo drains well within this
	task settle();
		repeat (24) @(posedge core_clk);
	endtask
	task readEntry(input logic [14:0] a);
		tblRdAddr <= a;
		repeat (2) @(posedge core_clk);
	endtask
	task t_reset();
		chk("stepPeriod", 72'h1, stepPeriod);
		chk("tblCount", 72'h0, tblCount);
		chk("serTxValid", 72'h0, serTxValid);
		repeat (2) @(posedge core_clk);
		chk("inputState", 72'h1, inputState);
		$display("t_reset done");
	endtask
	task t_setting();
		host.sendSer("S\nP7\r");
		settle();
		chk("stepPeriod", 72'h7, stepPeriod);
		host.sendPar("\nSP12\r");
		settle();
		chk("stepPeriod par", 72'hc, stepPeriod);
		$display("t_setting done");
	endtask
	// pairs sent X then Y, same kind, far below capacity
	task t_table();
		logic [15:0] x, y; // delta results, 16-bit wrap
		x = 16'h7530 + 16'he2a1;
		y = 16'h2ee0 + 16'h034f;
		host.sendSer("JX30000\rJY12000\rDL\rSS3\r");
		host.sendPar("JS4\r");
		host.sendSer("NX58017\rNY847\r");
		settle();
		chk("tblCount", 72'h2, tblCount);
		readEntry(15'h0);
		chk("entry0", {1'b0, 16'h7530, 16'h2ee0, 16'h1, 16'h1}, tblRdData);
		readEntry(15'h1);
		chk("entry1", {1'b1, x, y, 16'h3, 16'h4}, tblRdData);
		host.slowTx = 1'b1;
		host.replyQ.delete();
		host.sendSer("NX40000\r");
		for (int i = 0; i < 200 && host.replyQ.size() < 3; i++) @(posedge core_clk);
		chk("reply", 72'h49410d, {host.replyQ[0], host.replyQ[1], host.replyQ[2]});
		host.slowTx = 1'b0;
		host.sendSer("AB\rNX7000\rNY55000\r");
		settle();
		chk("tblCount", 72'h3, tblCount);
		readEntry(15'h2);
		chk("entry2", {1'b1, 16'h1b58, 16'hd6d8, 16'h3, 16'h4}, tblRdData);
		$display("t_table done");
	endtask
	task t_ignore();
		host.sendSer("QQ5\rSPx\rAB3\rNY5\r");
		settle();
		chk("stepPeriod", 72'hc, stepPeriod);
		chk("tblCount", 72'h3, tblCount);
		$display("t_ignore done");
	endtask
	task t_exec();
		execActive <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk("inputState", 72'h0, inputState);
		host.sendSer("SP9\rSP10");
		repeat (3) @(posedge core_clk);
		chk("serRxReady", 72'h0, serRxReady);
		chk("parBusy", 72'h1, parBusy);
		chk("stepPeriod", 72'hc, stepPeriod);
		execActive <= 1'b0;
		host.sendSer("\r");
		settle();
		chk("stepPeriod", 72'ha, stepPeriod);
		chk("serRxReady", 72'h1, serRxReady);
		$display("t_exec done");
	endtask
	task t_clear();
		tableClear <= 1'b1;
		@(posedge core_clk);
		tableClear <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk("tblCount", 72'h0, tblCount);
		$display("t_clear done");
	endtask
	task report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		rstn = 1'b0;
		execActive = 1'b0;
		tableClear = 1'b0;
		tblRdAddr = 15'h0;
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		t_reset();
		t_setting();
		t_table();
		t_ignore();
		t_exec();
		t_clear();
		report_and_stop();
	end
	// watchdog, far beyond the few hundred cycles expected
	initial begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		$display("[ERR] run expected done seen hang");
		report_and_stop();
	end
endmodule // vci_cmd_interp_test
`default_nettype wire
